// file: rtl/rtc_params.svh
// Purpose: Constants of the alarm-stop, tick trim and square-wave block.
// Assumes: Included by its bare name; definitions only.
// Notes: Offsets are the register numbers used on the control interface.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

`define ADDR_POWER_MANAGEMENT_FIVE 8'h0C
`define ADDR_CLOCK_TIME_CONTROL 8'h17
`define ADDR_TICK_TRIM_CONTROL 8'hDA

`define BIT_TICK_ENABLE 11
`define BIT_TICK_STATUS 14
`define BIT_ALARM_STOP_REQUEST 9
`define BIT_ALARM_STOP_STATUS 8
`define TRIM_MSB 9
`define TRIM_FRAC_BITS 6
`define SQW_SEL_MSB 3

`define RST_TICK_ENABLE 1'b1
`define RST_TICK_STATUS 1'b0
`define RST_ALARM_STOP_REQUEST 1'b1
`define RST_ALARM_STOP_STATUS 1'b1
`define RST_SQW_SEL 4'h0
`define RST_TRIM 10'h000

`define XTAL_NOMINAL_HZ 32768

`endif

// file: rtl/rtc_pkg.sv
// Purpose: Types shared by the tick trim block.
// Assumes: Nothing beyond the parameter header.
// Notes: Field widths follow the register layout.
package rtc_pkg;
	typedef logic [9:0] trim_t;
	typedef logic [3:0] sqw_sel_t;
	typedef logic [15:0] reg_word_t;
	typedef logic [15:0] tick_count_t;
endpackage : rtc_pkg

// file: rtl/osc_edge_filter.sv
// Purpose: Bring the crystal oscillator into the system clock domain.
// Assumes: Oscillator far slower than clk.
// Notes: A change counts once the second and third stages agree.
`timescale 1ns/1ps
module osc_edge_filter (
	input wire logic clk,
	input wire logic rstSyncN,
	input wire logic oscIn,
	output logic oscRise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
	} filt_t;

	filt_t q_r;
	filt_t q_nxt;

	always_comb begin
		q_nxt = q_r;
		q_nxt.s1 = oscIn;
		q_nxt.s2 = q_r.s1;
		q_nxt.s3 = q_r.s2;
		q_nxt.rise = 1'b0;
		if (q_r.s2 == q_r.s3 && q_r.s3 != q_r.level) begin
			q_nxt.level = q_r.s3;
			q_nxt.rise = q_r.s3;
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign oscRise = q_r.rise;
endmodule : osc_edge_filter

// file: rtl/rtc_alarm_trim_squarewave.sv
// Purpose: Alarm-stop handshake, trimmed one-second tick and square-wave output.
// Assumes: Time and alarm fields come from same-clock logic; oscillator is a pin.
// Notes: Register writes are single-cycle strobes from the control interface.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_alarm_trim_squarewave
	import rtc_pkg::*;
#(
	parameter int XTAL_HZ = `XTAL_NOMINAL_HZ,
	parameter int COUNT_W = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic xtalOsc,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrEn,
	output logic [15:0] regRdData,
	input wire logic securityUnlock,
	input wire logic [6:0] curSecs,
	input wire logic [6:0] curMins,
	input wire logic [4:0] curHrs,
	input wire logic curPm,
	input wire logic [3:0] curDay,
	input wire logic [5:0] curDate,
	input wire logic [4:0] curMth,
	input wire logic [6:0] almSecs,
	input wire logic [6:0] almMins,
	input wire logic [4:0] almHrs,
	input wire logic almPm,
	input wire logic [3:0] almDay,
	input wire logic [5:0] almDate,
	input wire logic [4:0] almMth,
	output logic alarmEvent,
	output logic secondTick,
	output logic squareWavePin
);
	// The compare against lastCount and the bit-15 overrun test assume this exact counter.
	if (XTAL_HZ != `XTAL_NOMINAL_HZ || COUNT_W != 16) begin : gBadParams
		$error("Tick counter built only for a 32768 Hz crystal and 16-bit count.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and oscillator input.

	logic rstMeta_r;
	logic rstSyncN;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta_r <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSyncN <= rstMeta_r;
		end
	end

	logic oscRise;

	osc_edge_filter oscFilter (
		.clk(clk),
		.rstSyncN(rstSyncN),
		.oscIn(xtalOsc),
		.oscRise(oscRise)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// A field whose alarm value is all ones matches any time.
	function automatic logic fieldHit(input logic [6:0] cur, input logic [6:0] alm, input logic [6:0] ones);
		fieldHit = ((alm & ones) == ones) || (cur == alm);
	endfunction : fieldHit

	// Square wave bit for select code n is counter bit 15-n, low while the
	// counter runs past the nominal second during a long trimmed period.
	function automatic logic squareBit(input tick_count_t cnt, input sqw_sel_t sel);
		logic [3:0] idx;
		idx = 4'hF - sel;
		if (sel == 4'h0 || cnt[15]) begin
			squareBit = 1'b0;
		end else begin
			squareBit = cnt[idx];
		end
	endfunction : squareBit

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic tickEna;
		logic tickSts;
		logic almReq;
		logic almSts;
		sqw_sel_t sqwSel;
		trim_t trim;
		logic [5:0] fracAcc;
		tick_count_t cnt;
		logic matchPrev;
		logic alarmEvent;
		logic secondTick;
		logic sqWave;
		reg_word_t rdData;
	} state_t;

	state_t q_r;
	state_t q_nxt;

	logic timeMatch;
	logic [6:0] fracSum;
	tick_count_t lastCount;

	always_comb begin
		timeMatch = fieldHit(curSecs, almSecs, 7'h7F) && fieldHit(curMins, almMins, 7'h7F)
			&& ((&almHrs) || {curPm, curHrs} == {almPm, almHrs})
			&& fieldHit({3'h0, curDay}, {3'h0, almDay}, 7'h0F)
			&& fieldHit({1'h0, curDate}, {1'h0, almDate}, 7'h3F)
			&& fieldHit({2'h0, curMth}, {2'h0, almMth}, 7'h1F);
		// The fraction of the trim accumulates; each carry adds one more
		// oscillator period, so the error averages out over seconds.
		fracSum = {1'b0, q_r.fracAcc} + {1'b0, q_r.trim[5:0]};
		lastCount = 16'h7FFF + {{12{q_r.trim[`TRIM_MSB]}}, q_r.trim[9:6]} + {15'h0000, fracSum[6]};
	end

	always_comb begin
		q_nxt = q_r;
		q_nxt.alarmEvent = 1'b0;
		q_nxt.secondTick = 1'b0;
		q_nxt.matchPrev = timeMatch;

		if (regWrEn) begin
			if (regAddr == `ADDR_POWER_MANAGEMENT_FIVE) begin
				q_nxt.tickEna = regWrData[`BIT_TICK_ENABLE];
			end else if (regAddr == `ADDR_TICK_TRIM_CONTROL) begin
				q_nxt.tickEna = regWrData[`BIT_TICK_ENABLE];
				if (securityUnlock) begin
					q_nxt.trim = regWrData[`TRIM_MSB:0];
				end
			end else if (regAddr == `ADDR_CLOCK_TIME_CONTROL) begin
				q_nxt.almReq = regWrData[`BIT_ALARM_STOP_REQUEST];
				q_nxt.sqwSel = regWrData[`SQW_SEL_MSB:0];
			end
		end

		// Status bits change only on an oscillator edge, after the request
		// has been sampled there; software never writes them.
		if (oscRise) begin
			q_nxt.tickSts = q_r.tickEna;
			q_nxt.almSts = q_r.almReq;
			if (q_r.tickSts) begin
				if (q_r.cnt >= lastCount) begin
					q_nxt.cnt = 16'h0000;
					q_nxt.fracAcc = fracSum[5:0];
					q_nxt.secondTick = 1'b1;
				end else begin
					q_nxt.cnt = q_r.cnt + 16'h0001;
				end
			end
		end

		// Alarms stay silent while either the request or the status says stopped.
		if (timeMatch && !q_r.matchPrev && !q_r.almReq && !q_r.almSts) begin
			q_nxt.alarmEvent = 1'b1;
		end

		q_nxt.sqWave = squareBit(q_nxt.cnt, q_r.sqwSel);

		q_nxt.rdData = 16'h0000;
		if (regAddr == `ADDR_POWER_MANAGEMENT_FIVE) begin
			q_nxt.rdData[`BIT_TICK_ENABLE] = q_r.tickEna;
		end else if (regAddr == `ADDR_TICK_TRIM_CONTROL) begin
			q_nxt.rdData[`BIT_TICK_STATUS] = q_r.tickSts;
			q_nxt.rdData[`BIT_TICK_ENABLE] = q_r.tickEna;
			q_nxt.rdData[`TRIM_MSB:0] = q_r.trim;
		end else if (regAddr == `ADDR_CLOCK_TIME_CONTROL) begin
			q_nxt.rdData[`BIT_ALARM_STOP_REQUEST] = q_r.almReq;
			q_nxt.rdData[`BIT_ALARM_STOP_STATUS] = q_r.almSts;
			q_nxt.rdData[`SQW_SEL_MSB:0] = q_r.sqwSel;
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			q_r <= '0;
			q_r.tickEna <= `RST_TICK_ENABLE;
			q_r.tickSts <= `RST_TICK_STATUS;
			q_r.almReq <= `RST_ALARM_STOP_REQUEST;
			q_r.almSts <= `RST_ALARM_STOP_STATUS;
			q_r.sqwSel <= `RST_SQW_SEL;
			q_r.trim <= `RST_TRIM;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign regRdData = q_r.rdData;
	assign alarmEvent = q_r.alarmEvent;
	assign secondTick = q_r.secondTick;
	assign squareWavePin = q_r.sqWave;
endmodule : rtc_alarm_trim_squarewave

// file: tb/xtal_src.sv
// Purpose: Free-running crystal stand-in for the tick and square-wave logic.
// Assumes: Ten system clocks per oscillator period.
// Notes: Runs fast so that status and square-wave changes show in a short run.
`timescale 1ns/1ps
module xtal_src (
	output logic osc
);
	initial osc = 1'b0;
	always #50 osc = ~osc;
endmodule : xtal_src

// file: tb/rtc_chk.sv
// Purpose: Port-level checks of the alarm, tick and register behaviour.
// Assumes: Single clock domain.
// Notes: Reads show the addressed contents one cycle later.
`timescale 1ns/1ps
module rtc_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic securityUnlock,
	input wire logic [15:0] regRdData,
	input wire logic [6:0] curSecs,
	input wire logic [6:0] almSecs,
	input wire logic alarmEvent,
	input wire logic secondTick,
	input wire logic squareWavePin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_quiet;
		regAddr == 8'hDA && !(regWrEn && securityUnlock);
	endsequence
	sequence s_alias;
		(regAddr == 8'h0C && !regWrEn) ##1 (regAddr == 8'hDA && !regWrEn);
	endsequence
	a_alarm_single: assert property (alarmEvent |=> !alarmEvent) else $error("alarm pulse too long");
	a_alarm_cause: assert property (alarmEvent |-> $past(curSecs == almSecs || &almSecs))
		else $error("alarm without match");
	a_alarm_blocked: assert property ($past(regAddr) == 8'h17 && regRdData[9] && !$past(regWrEn) && !regWrEn
		|=> !alarmEvent) else $error("alarm while stopped");
	a_tick_single: assert property (secondTick |=> !secondTick) else $error("tick pulse too long");
	a_trim_locked: assert property (s_quiet [*3] |=> $stable(regRdData[9:0])) else $error("trim changed");
	a_enable_alias: assert property (s_alias |=> regRdData[11] == $past(regRdData[11]))
		else $error("enable alias differs");
	a_ctl_spare: assert property (regAddr == 8'h17 |=> regRdData[15:10] == 6'h00 && regRdData[7:4] == 4'h0)
		else $error("spare bits set");
	a_reset_quiet: assert property ($rose(rstn) |-> !alarmEvent && !secondTick && !squareWavePin)
		else $error("outputs active after reset");
endmodule : rtc_chk
bind rtc_alarm_trim_squarewave rtc_chk chk (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
	.securityUnlock(securityUnlock), .regRdData(regRdData), .curSecs(curSecs), .almSecs(almSecs),
	.alarmEvent(alarmEvent), .secondTick(secondTick), .squareWavePin(squareWavePin));

// file: tb/tb_top.sv
// Purpose: Register-level tests of the alarm-stop, trim and square-wave block.
// Assumes: Time and alarm fields are slices of two bench words.
// Notes: No second rollover is reached; the checker watches the tick pulse.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
	logic clk = 1'b0, rstn = 1'b0, regWrEn = 1'b0, securityUnlock = 1'b0, osc, lastPin = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000, regRdData;
	logic [6:0] cS = 7'h00, aS = 7'h00;
	logic alarmEvent, secondTick, squareWavePin;
	int err_total = 0, checks_done = 0, cyc = 0, evCnt = 0, tog = 0, togHold = 0, tickSeen = 0;
	always #5 clk = ~clk;
	xtal_src xs (.osc(osc));
	rtc_alarm_trim_squarewave dut (.clk(clk), .rstn(rstn), .xtalOsc(osc), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData), .securityUnlock(securityUnlock),
		.curSecs(cS), .curMins(cS), .curHrs(cS[4:0]), .curPm(cS[0]), .curDay(cS[3:0]), .curDate(cS[5:0]),
		.curMth(cS[4:0]), .almSecs(aS), .almMins(aS), .almHrs(aS[4:0]), .almPm(aS[0]), .almDay(aS[3:0]),
		.almDate(aS[5:0]), .almMth(aS[4:0]), .alarmEvent(alarmEvent), .secondTick(secondTick),
		.squareWavePin(squareWavePin));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk) begin regAddr <= a; regWrData <= d; regWrEn <= 1'b1; end
		@(posedge clk) regWrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk) regAddr <= a;
		repeat (2) @(posedge clk);
		#1 `CHK(regRdData, e)
	endtask : rd
	always @(posedge clk) begin
		cyc++;
		if (alarmEvent === 1'b1) evCnt++;
		if (secondTick === 1'b1) tickSeen++;
		if (squareWavePin !== lastPin) tog++;
		lastPin <= squareWavePin;
		if (cyc == 5000) begin err_total++; stop_test(); end
	end
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (40) @(posedge clk);
		rd(8'h17, 16'h0300);
		rd(8'hDA, 16'h4800);
		rd(8'h0C, 16'h0800);
		rd(8'hB0, 16'h0000);
		`CHK(tog, 0)
		@(posedge clk) aS <= 7'h05;
		$display("reset values done");
		@(posedge clk) cS <= 7'h05;
		repeat (5) @(posedge clk);
		`CHK(evCnt, 0)
		wr(8'h17, 16'h010F);
		repeat (40) @(posedge clk);
		rd(8'h17, 16'h000F);
		@(posedge clk) cS <= 7'h04;
		@(posedge clk) cS <= 7'h05;
		repeat (3) @(posedge clk);
		`CHK(evCnt, 1)
		`CHK(tog > 2, 1'b1)
		$display("alarm and square wave done");
		wr(8'hDA, 16'h0BFF);
		rd(8'hDA, 16'h4800);
		wr(8'h0C, 16'h0000);
		repeat (40) @(posedge clk);
		rd(8'hDA, 16'h0000);
		togHold = tog;
		repeat (30) @(posedge clk);
		`CHK(tog, togHold)
		@(posedge clk) securityUnlock <= 1'b1;
		wr(8'hDA, 16'h02F2);
		rd(8'hDA, 16'h02F2);
		rd(8'h0C, 16'h0000);
		wr(8'h0C, 16'h0800);
		repeat (40) @(posedge clk);
		rd(8'h0C, 16'h0800);
		rd(8'hDA, 16'h4AF2);
		`CHK(tickSeen, 0)
		$display("trim and enable done");
		stop_test();
	end
endmodule : tb_top
